// ---- inc/pxb_pkg.sv ----
// Shared constants and types for the port pin crossbar block
package pxb_pkg;

    // Pin and function counts, widths and fixed pin numbers
    localparam int PXB_NPIN = 17;
    localparam int PXB_NXPIN = 16;
    localparam int PXB_NFN = 17;
    localparam int PXB_FNW = 5;
    localparam int PXB_AW = 6;
    localparam int PXB_DW = 32;
    localparam int PXB_DBG_PIN = 16;
    localparam int PXB_UART_TX_PIN = 4;
    localparam int PXB_UART_RX_PIN = 5;

    // Register byte offsets
    localparam logic [PXB_AW-1:0] PXB_OFS_LATCH0 = 6'h00;
    localparam logic [PXB_AW-1:0] PXB_OFS_LATCH1 = 6'h04;
    localparam logic [PXB_AW-1:0] PXB_OFS_LATCH2 = 6'h08;
    localparam logic [PXB_AW-1:0] PXB_OFS_IN_MODE0 = 6'h0c;
    localparam logic [PXB_AW-1:0] PXB_OFS_IN_MODE1 = 6'h10;
    localparam logic [PXB_AW-1:0] PXB_OFS_OUT_MODE0 = 6'h14;
    localparam logic [PXB_AW-1:0] PXB_OFS_OUT_MODE1 = 6'h18;
    localparam logic [PXB_AW-1:0] PXB_OFS_SKIP0 = 6'h1c;
    localparam logic [PXB_AW-1:0] PXB_OFS_SKIP1 = 6'h20;
    localparam logic [PXB_AW-1:0] PXB_OFS_SEL_A = 6'h24;
    localparam logic [PXB_AW-1:0] PXB_OFS_SEL_B = 6'h28;

    // Reset values
    localparam logic [7:0] PXB_LATCH_RST = 8'hff;
    localparam logic [7:0] PXB_IN_MODE_RST = 8'hff;
    localparam logic [7:0] PXB_OUT_MODE_RST = 8'h00;
    localparam logic [7:0] PXB_SKIP_RST = 8'h00;
    localparam logic [7:0] PXB_SEL_RST = 8'h00;

    // crossbar_select_a fields
    localparam int PXB_SA_UART = 0;
    localparam int PXB_SA_SPI = 1;
    localparam int PXB_SA_SMB = 2;
    localparam int PXB_SA_SYSCLK = 3;
    localparam int PXB_SA_CP0 = 4;
    localparam int PXB_SA_COMPARATOR_ASYNC_OUTPUT = 5;

    // crossbar_select_b fields
    localparam int PXB_SB_CEX_LSB = 0;
    localparam int PXB_SB_CEX_W = 2;
    localparam int PXB_SB_ECI = 2;
    localparam int PXB_SB_T0 = 3;
    localparam int PXB_SB_T1 = 4;
    localparam int PXB_SB_XBAR_EN = 6;
    localparam int PXB_SB_WPUD = 7;

    // Function indices, in crossbar priority order
    localparam int PXB_FN_UART_TX = 0;
    localparam int PXB_FN_UART_RX = 1;
    localparam int PXB_FN_SPI_SCK = 2;
    localparam int PXB_FN_SPI_MISO = 3;
    localparam int PXB_FN_SPI_MOSI = 4;
    localparam int PXB_FN_SPI_NSS = 5;
    localparam int PXB_FN_SMB_SDA = 6;
    localparam int PXB_FN_SMB_SCL = 7;
    localparam int PXB_FN_CP0 = 8;
    localparam int PXB_FN_COMPARATOR_ASYNC_OUTPUT = 9;
    localparam int PXB_FN_SYSCLK = 10;
    localparam int PXB_FN_CEX0 = 11;
    localparam int PXB_FN_ECI = 14;
    localparam int PXB_FN_T0 = 15;
    localparam int PXB_FN_T1 = 16;
    localparam int PXB_NCEX = 3;

    typedef struct packed {
        logic read;
        logic write;
        logic [PXB_AW-1:0] address;
        logic [PXB_DW-1:0] writedata;
        logic [3:0] byteenable;
    } pxb_avl_req_s;

    typedef struct packed {
        logic o;
        logic oe;
        logic pu;
    } pxb_cell_state_s;

    typedef struct packed {
        logic [7:0] latch0;
        logic [7:0] latch1;
        logic latch2;
        logic [7:0] in_mode0;
        logic [7:0] in_mode1;
        logic [7:0] out_mode0;
        logic [7:0] out_mode1;
        logic [7:0] skip0;
        logic [7:0] skip1;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic ack;
        logic [PXB_DW-1:0] rdata;
        logic [PXB_NFN-1:0] fn_in;
    } pxb_state_s;

endpackage

// ---- rtl/pxb_pad_cell.sv ----
// One port pad cell: output stage, weak pull-up and input receiver
`timescale 1ns/1ps
module pxb_pad_cell
    import pxb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Configuration
    input wire logic digital_i,
    input wire logic push_pull_i,
    input wire logic pullup_disable_i,
    // Output request
    input wire logic drive_en_i,
    input wire logic value_i,
    // Pad
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic pullup_o,
    // Readback
    output logic level_o
);

    pxb_cell_state_s state_reg;
    pxb_cell_state_s state_next;

    always_comb begin
        logic drive;
        logic low;
        logic high;
        drive = digital_i & drive_en_i;
        low = drive & ~value_i;
        high = drive & value_i & push_pull_i;
        state_next.o = value_i;
        state_next.oe = low | high;
        state_next.pu = digital_i & ~pullup_disable_i & ~(low | high);
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= '{o: 1'b1, oe: 1'b0, pu: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pad_o = state_reg.o;
    assign pad_oe_o = state_reg.oe;
    assign pullup_o = state_reg.pu;
    assign level_o = digital_i & pad_i;

endmodule

// ---- rtl/pxb_port_crossbar.sv ----
// Port pin configuration, priority crossbar and register slave
`timescale 1ns/1ps
module pxb_port_crossbar
    import pxb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Avalon-MM slave
    input wire pxb_avl_req_s avs_req_i,
    output logic [PXB_DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Port pads
    input wire logic [PXB_NPIN-1:0] pad_i,
    output logic [PXB_NPIN-1:0] pad_o,
    output logic [PXB_NPIN-1:0] pad_oe_o,
    output logic [PXB_NPIN-1:0] pullup_o,
    // Peripheral functions
    input wire logic [PXB_NFN-1:0] fn_out_i,
    input wire logic [PXB_NFN-1:0] fn_oe_i,
    output logic [PXB_NFN-1:0] fn_in_o,
    output logic [PXB_NFN-1:0] fn_placed_o,
    // Debug data pin
    input wire logic debug_active_i,
    input wire logic debug_out_i,
    input wire logic debug_oe_i,
    output logic debug_in_o
);

    pxb_state_s state_reg;
    pxb_state_s state_next;

    logic crossbar_enable;
    logic weak_pullup_disable;
    logic [PXB_NFN-1:0] fn_en;
    logic [PXB_NPIN-1:0] pin_asg;
    logic [PXB_FNW-1:0] pin_fn [PXB_NPIN];
    logic [PXB_NPIN-1:0] pin_dig;
    logic [PXB_NPIN-1:0] pin_pp;
    logic [PXB_NPIN-1:0] pin_drv;
    logic [PXB_NPIN-1:0] pin_val;
    logic [PXB_NPIN-1:0] pin_level;
    logic [PXB_NFN-1:0] placed;

    assign crossbar_enable = state_reg.sel_b[PXB_SB_XBAR_EN];
    assign weak_pullup_disable = state_reg.sel_b[PXB_SB_WPUD];

    // Function enables from the two select registers
    always_comb begin
        logic [PXB_SB_CEX_W-1:0] cex_cnt;
        cex_cnt = state_reg.sel_b[PXB_SB_CEX_LSB +: PXB_SB_CEX_W];
        fn_en = '0;
        fn_en[PXB_FN_UART_TX] = state_reg.sel_a[PXB_SA_UART];
        fn_en[PXB_FN_UART_RX] = state_reg.sel_a[PXB_SA_UART];
        fn_en[PXB_FN_SPI_SCK] = state_reg.sel_a[PXB_SA_SPI];
        fn_en[PXB_FN_SPI_MISO] = state_reg.sel_a[PXB_SA_SPI];
        fn_en[PXB_FN_SPI_MOSI] = state_reg.sel_a[PXB_SA_SPI];
        fn_en[PXB_FN_SPI_NSS] = state_reg.sel_a[PXB_SA_SPI];
        fn_en[PXB_FN_SMB_SDA] = state_reg.sel_a[PXB_SA_SMB];
        fn_en[PXB_FN_SMB_SCL] = state_reg.sel_a[PXB_SA_SMB];
        fn_en[PXB_FN_CP0] = state_reg.sel_a[PXB_SA_CP0];
        fn_en[PXB_FN_COMPARATOR_ASYNC_OUTPUT] = state_reg.sel_a[PXB_SA_COMPARATOR_ASYNC_OUTPUT];
        fn_en[PXB_FN_SYSCLK] = state_reg.sel_a[PXB_SA_SYSCLK];
        for (int k = 0; k < PXB_NCEX; k++) begin
            fn_en[PXB_FN_CEX0 + k] = (k < int'(cex_cnt));
        end
        fn_en[PXB_FN_ECI] = state_reg.sel_b[PXB_SB_ECI];
        fn_en[PXB_FN_T0] = state_reg.sel_b[PXB_SB_T0];
        fn_en[PXB_FN_T1] = state_reg.sel_b[PXB_SB_T1];
    end

    // Priority decode: UART takes fixed pins 4 and 5, each other enabled function the lowest free pin
    always_comb begin
        logic [PXB_NXPIN-1:0] taken;
        logic found;
        taken = {state_reg.skip1, state_reg.skip0};
        found = 1'b0;
        pin_asg = '0;
        placed = '0;
        for (int p = 0; p < PXB_NPIN; p++) begin
            pin_fn[p] = '0;
        end
        if (fn_en[PXB_FN_UART_TX]) begin
            pin_asg[PXB_UART_TX_PIN] = 1'b1;
            pin_fn[PXB_UART_TX_PIN] = PXB_FNW'(PXB_FN_UART_TX);
            pin_asg[PXB_UART_RX_PIN] = 1'b1;
            pin_fn[PXB_UART_RX_PIN] = PXB_FNW'(PXB_FN_UART_RX);
            taken[PXB_UART_TX_PIN] = 1'b1;
            taken[PXB_UART_RX_PIN] = 1'b1;
            placed[PXB_FN_UART_TX] = 1'b1;
            placed[PXB_FN_UART_RX] = 1'b1;
        end
        for (int f = PXB_FN_SPI_SCK; f < PXB_NFN; f++) begin
            found = 1'b0;
            if (fn_en[f]) begin
                for (int p = 0; p < PXB_NXPIN; p++) begin
                    if (!found && !taken[p]) begin
                        found = 1'b1;
                        taken[p] = 1'b1;
                        pin_asg[p] = 1'b1;
                        pin_fn[p] = PXB_FNW'(f);
                        placed[f] = 1'b1;
                    end
                end
            end
        end
    end

    // Per-pin configuration and output request
    always_comb begin
        logic smb;
        logic [PXB_NXPIN-1:0] dig_cfg;
        logic [PXB_NXPIN-1:0] pp_cfg;
        logic [PXB_NXPIN-1:0] lat_cfg;
        smb = 1'b0;
        dig_cfg = {state_reg.in_mode1, state_reg.in_mode0};
        pp_cfg = {state_reg.out_mode1, state_reg.out_mode0};
        lat_cfg = {state_reg.latch1, state_reg.latch0};
        pin_dig = '0;
        pin_pp = '0;
        pin_drv = '0;
        pin_val = '0;
        for (int p = 0; p < PXB_NXPIN; p++) begin
            // Analog functions use fixed or any pins through the input-mode bit alone
            pin_dig[p] = dig_cfg[p];
            smb = pin_asg[p] && (pin_fn[p] == PXB_FNW'(PXB_FN_SMB_SDA) ||
                                 pin_fn[p] == PXB_FNW'(PXB_FN_SMB_SCL));
            pin_pp[p] = pp_cfg[p] & ~smb;
            if (pin_asg[p]) begin
                pin_val[p] = fn_out_i[pin_fn[p]];
                pin_drv[p] = crossbar_enable & fn_oe_i[pin_fn[p]];
            end else begin
                pin_val[p] = lat_cfg[p];
                pin_drv[p] = crossbar_enable;
            end
        end
        pin_dig[PXB_DBG_PIN] = 1'b1;
        if (debug_active_i) begin
            pin_val[PXB_DBG_PIN] = debug_out_i;
            pin_drv[PXB_DBG_PIN] = debug_oe_i;
            pin_pp[PXB_DBG_PIN] = 1'b1;
        end else begin
            pin_val[PXB_DBG_PIN] = state_reg.latch2;
            pin_drv[PXB_DBG_PIN] = crossbar_enable;
        end
    end

    // Pad cells
    generate
        for (genvar g = 0; g < PXB_NPIN; g++) begin : g_pad
            pxb_pad_cell u_cell (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .digital_i(pin_dig[g]),
                .push_pull_i(pin_pp[g]),
                .pullup_disable_i(weak_pullup_disable),
                .drive_en_i(pin_drv[g]),
                .value_i(pin_val[g]),
                .pad_i(pad_i[g]),
                .pad_o(pad_o[g]),
                .pad_oe_o(pad_oe_o[g]),
                .pullup_o(pullup_o[g]),
                .level_o(pin_level[g])
            );
        end
    endgenerate

    // Register slave, peripheral inputs
    always_comb begin
        logic req;
        logic [7:0] wbyte;
        logic [PXB_DW-1:0] rd;
        req = avs_req_i.read | avs_req_i.write;
        wbyte = avs_req_i.writedata[7:0];
        rd = '0;
        state_next = state_reg;

        // Read data captured on the first cycle, presented while waitrequest is low
        if (avs_req_i.address == PXB_OFS_LATCH0) begin
            rd[7:0] = pin_level[7:0];
        end else if (avs_req_i.address == PXB_OFS_LATCH1) begin
            rd[7:0] = pin_level[15:8];
        end else if (avs_req_i.address == PXB_OFS_LATCH2) begin
            rd[0] = pin_level[PXB_DBG_PIN];
        end else if (avs_req_i.address == PXB_OFS_IN_MODE0) begin
            rd[7:0] = state_reg.in_mode0;
        end else if (avs_req_i.address == PXB_OFS_IN_MODE1) begin
            rd[7:0] = state_reg.in_mode1;
        end else if (avs_req_i.address == PXB_OFS_OUT_MODE0) begin
            rd[7:0] = state_reg.out_mode0;
        end else if (avs_req_i.address == PXB_OFS_OUT_MODE1) begin
            rd[7:0] = state_reg.out_mode1;
        end else if (avs_req_i.address == PXB_OFS_SKIP0) begin
            rd[7:0] = state_reg.skip0;
        end else if (avs_req_i.address == PXB_OFS_SKIP1) begin
            rd[7:0] = state_reg.skip1;
        end else if (avs_req_i.address == PXB_OFS_SEL_A) begin
            rd[7:0] = state_reg.sel_a;
        end else if (avs_req_i.address == PXB_OFS_SEL_B) begin
            rd[7:0] = state_reg.sel_b;
        end

        state_next.ack = req & ~state_reg.ack;
        if (req && !state_reg.ack && avs_req_i.read) begin
            state_next.rdata = rd;
        end

        if (state_reg.ack && avs_req_i.write && avs_req_i.byteenable[0]) begin
            if (avs_req_i.address == PXB_OFS_LATCH0) begin
                state_next.latch0 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_LATCH1) begin
                state_next.latch1 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_LATCH2) begin
                state_next.latch2 = wbyte[0];
            end else if (avs_req_i.address == PXB_OFS_IN_MODE0) begin
                state_next.in_mode0 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_IN_MODE1) begin
                state_next.in_mode1 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_OUT_MODE0) begin
                state_next.out_mode0 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_OUT_MODE1) begin
                state_next.out_mode1 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_SKIP0) begin
                state_next.skip0 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_SKIP1) begin
                state_next.skip1 = wbyte;
            end else if (avs_req_i.address == PXB_OFS_SEL_A) begin
                state_next.sel_a = wbyte;
            end else if (avs_req_i.address == PXB_OFS_SEL_B) begin
                state_next.sel_b = wbyte;
            end
        end

        // Unplaced functions see an idle high input
        for (int f = 0; f < PXB_NFN; f++) begin
            state_next.fn_in[f] = 1'b1;
        end
        for (int p = 0; p < PXB_NXPIN; p++) begin
            if (pin_asg[p]) begin
                state_next.fn_in[pin_fn[p]] = pin_level[p];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg.latch0 <= PXB_LATCH_RST;
            state_reg.latch1 <= PXB_LATCH_RST;
            state_reg.latch2 <= 1'b1;
            state_reg.in_mode0 <= PXB_IN_MODE_RST;
            state_reg.in_mode1 <= PXB_IN_MODE_RST;
            state_reg.out_mode0 <= PXB_OUT_MODE_RST;
            state_reg.out_mode1 <= PXB_OUT_MODE_RST;
            state_reg.skip0 <= PXB_SKIP_RST;
            state_reg.skip1 <= PXB_SKIP_RST;
            state_reg.sel_a <= PXB_SEL_RST;
            state_reg.sel_b <= PXB_SEL_RST;
            state_reg.ack <= 1'b0;
            state_reg.rdata <= '0;
            state_reg.fn_in <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_waitrequest_o = (avs_req_i.read | avs_req_i.write) & ~state_reg.ack;
    assign avs_readdata_o = state_reg.rdata;
    assign fn_in_o = state_reg.fn_in;
    assign fn_placed_o = placed;
    assign debug_in_o = pin_level[PXB_DBG_PIN];

endmodule

// ---- verif/pxb_port_crossbar_checker.sv ----
// Concurrent checks on the port crossbar ports
`timescale 1ns/1ps
module pxb_port_crossbar_checker
    import pxb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register bus
    input wire pxb_avl_req_s avs_req_i,
    input wire logic avs_waitrequest_o,
    // Pads
    input wire logic [PXB_NPIN-1:0] pad_i,
    input wire logic [PXB_NPIN-1:0] pad_o,
    input wire logic [PXB_NPIN-1:0] pad_oe_o,
    input wire logic [PXB_NPIN-1:0] pullup_o,
    // Functions and debug
    input wire logic [PXB_NFN-1:0] fn_in_o,
    input wire logic [PXB_NFN-1:0] fn_placed_o,
    input wire logic debug_active_i,
    input wire logic debug_out_i,
    input wire logic debug_oe_i,
    input wire logic debug_in_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic rq;
    logic wr_done;
    logic [7:0] sel_a_reg;
    logic xen_reg;
    logic wpud_reg;
    assign rq = avs_req_i.read | avs_req_i.write;
    assign wr_done = avs_req_i.write & ~avs_waitrequest_o & avs_req_i.byteenable[0];
    // Shadow of the selects, updated at the completing edge
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_a_reg <= PXB_SEL_RST;
            xen_reg <= 1'b0;
            wpud_reg <= 1'b0;
        end else if (wr_done && avs_req_i.address == PXB_OFS_SEL_A) begin
            sel_a_reg <= avs_req_i.writedata[7:0];
        end else if (wr_done && avs_req_i.address == PXB_OFS_SEL_B) begin
            xen_reg <= avs_req_i.writedata[PXB_SB_XBAR_EN];
            wpud_reg <= avs_req_i.writedata[PXB_SB_WPUD];
        end
    end
    sequence s_start; $rose(rq); endsequence
    sequence s_one_wait; avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
    property p_wait_one; s_start |-> s_one_wait; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle");
    property p_wait_req; avs_waitrequest_o |-> rq; endproperty
    a_wait_req: assert property (p_wait_req) else $error("waitrequest without request");
    property p_drv_off; !xen_reg && !$past(xen_reg) |-> pad_oe_o[PXB_NXPIN-1:0] == '0; endproperty
    a_drv_off: assert property (p_drv_off) else $error("pad driven with crossbar off");
    property p_pu_low; (pad_oe_o & ~pad_o & pullup_o) == '0; endproperty
    a_pu_low: assert property (p_pu_low) else $error("pull-up on while driving low");
    property p_wpud; wpud_reg && $past(wpud_reg) |-> pullup_o == '0; endproperty
    a_wpud: assert property (p_wpud) else $error("pull-up on while globally off");
    property p_uart; xen_reg && sel_a_reg[PXB_SA_UART] |-> fn_placed_o[1:0] == 2'b11; endproperty
    a_uart: assert property (p_uart) else $error("uart pins not placed");
    property p_fn_idle; (~$past(fn_placed_o) & ~fn_in_o) == '0; endproperty
    a_fn_idle: assert property (p_fn_idle) else $error("unplaced function input low");
    property p_dbg_drive;
        debug_active_i && debug_oe_i |=> pad_oe_o[PXB_DBG_PIN] && pad_o[PXB_DBG_PIN] == $past(debug_out_i);
    endproperty
    a_dbg_drive: assert property (p_dbg_drive) else $error("debug pin not driven");
    property p_dbg_in; debug_in_o == pad_i[PXB_DBG_PIN]; endproperty
    a_dbg_in: assert property (p_dbg_in) else $error("debug input not pad level");
endmodule
bind pxb_port_crossbar pxb_port_crossbar_checker u_pxb_port_crossbar_checker (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .avs_req_i(avs_req_i), .avs_waitrequest_o(avs_waitrequest_o), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pullup_o(pullup_o), .fn_in_o(fn_in_o), .fn_placed_o(fn_placed_o),
    .debug_active_i(debug_active_i), .debug_out_i(debug_out_i), .debug_oe_i(debug_oe_i),
    .debug_in_o(debug_in_o));

// ---- verif/pxb_pad_model.sv ----
// External circuitry on the port pads
`timescale 1ns/1ps
module pxb_pad_model
    import pxb_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Device side
    input wire logic [PXB_NPIN-1:0] pad_o_i,
    input wire logic [PXB_NPIN-1:0] pad_oe_i,
    input wire logic [PXB_NPIN-1:0] pullup_i,
    // Outside drivers
    input wire logic [PXB_NPIN-1:0] ext_en_i,
    input wire logic [PXB_NPIN-1:0] ext_val_i,
    // Resolved pad level
    output logic [PXB_NPIN-1:0] level_o
);
    logic [PXB_NPIN-1:0] noise_reg;
    initial noise_reg = '0;
    always @(posedge sys_clk_i) begin
        noise_reg <= ~noise_reg;
    end
    // Floating or fought-over pads show a changing level, never a stale one
    always_comb begin
        for (int i = 0; i < PXB_NPIN; i++) begin
            if (pad_oe_i[i] && ext_en_i[i] && pad_o_i[i] !== ext_val_i[i]) level_o[i] = noise_reg[i];
            else if (pad_oe_i[i]) level_o[i] = pad_o_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pullup_i[i]) level_o[i] = 1'b1;
            else level_o[i] = noise_reg[i];
        end
    end
endmodule

// ---- verif/pxb_port_crossbar_test.sv ----
// Self-checking bench for the port crossbar
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module pxb_port_crossbar_test
    import pxb_pkg::*;
;
    logic sys_clk_i;
    logic sys_rst_i;
    pxb_avl_req_s req;
    logic [PXB_DW-1:0] rdata;
    logic wreq;
    logic [PXB_NPIN-1:0] pad_lvl, pad_out, pad_oe, pull, ext_en, ext_val;
    logic [PXB_NFN-1:0] fn_out, fn_oe, fn_in, fn_placed;
    logic dbg_act, dbg_out, dbg_oe, dbg_in, probe, m_b;
    logic [2*PXB_NFN:0] obs;
    int bad_count, checks, seed, pidx;
    logic [31:0] exp_q[$];
    logic look_q[$];
    logic [31:0] v, m_exp;
    logic [7:0] rst_tab[12] = '{8'hff, 8'hff, 8'h01, PXB_IN_MODE_RST, PXB_IN_MODE_RST, PXB_OUT_MODE_RST,
        PXB_OUT_MODE_RST, PXB_SKIP_RST, PXB_SKIP_RST, PXB_SEL_RST, PXB_SEL_RST, 8'h00};
    assign obs = {dbg_in, fn_placed, fn_in};
    pxb_port_crossbar u_pxb_port_crossbar (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_req_i(req),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pad_i(pad_lvl), .pad_o(pad_out), .pad_oe_o(pad_oe),
        .pullup_o(pull), .fn_out_i(fn_out), .fn_oe_i(fn_oe), .fn_in_o(fn_in), .fn_placed_o(fn_placed),
        .debug_active_i(dbg_act), .debug_out_i(dbg_out), .debug_oe_i(dbg_oe), .debug_in_o(dbg_in));
    pxb_pad_model u_pxb_pad_model (.sys_clk_i(sys_clk_i), .pad_o_i(pad_out), .pad_oe_i(pad_oe),
        .pullup_i(pull), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad_lvl));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [PXB_AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge sys_clk_i);
        req <= '{read: ~w, write: w, address: a, writedata: d, byteenable: be};
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (wreq !== 1'b0) begin
            bad_count++;
            test_done();
        end
        req <= '0;
    endtask
    task automatic wr(input logic [PXB_AW-1:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hf);
    endtask
    task automatic rd(input logic [PXB_AW-1:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic look(input int idx, input logic e);
        look_q.push_back(e);
        repeat (3) @(posedge sys_clk_i);
        pidx <= idx;
        probe <= 1'b1;
        @(posedge sys_clk_i);
        probe <= 1'b0;
    endtask
    // Takes the oldest note whenever a result appears
    always @(posedge sys_clk_i) begin
        if (req.read === 1'b1 && wreq === 1'b0) begin
            m_exp = exp_q.pop_front();
            `CHK("readdata", m_exp, rdata)
        end
        if (probe === 1'b1) begin
            m_b = look_q.pop_front();
            `CHK("observed", m_b, obs[pidx])
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        test_done();
    end
    initial begin
        seed = 85997;
        req = '0;
        {ext_en, ext_val, fn_out, fn_oe} = '0;
        {dbg_act, dbg_out, dbg_oe, probe} = '0;
        {pidx, bad_count, checks} = '0;
        sys_rst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        foreach (rst_tab[i]) rd(6'(i * 4), rst_tab[i]);
        for (int i = 3; i < 9; i++) begin
            v = $random(seed);
            wr(6'(i * 4), v[7:0]);
            rd(6'(i * 4), v[7:0]);
            wr(6'(i * 4), rst_tab[i]);
        end
        bus(1'b1, PXB_OFS_SKIP0, 32'hff, 4'he);
        rd(PXB_OFS_SKIP0, 8'h00);
        wr(6'h2c, 8'h5a);
        rd(6'h2c, 8'h00);
        rd(6'h3c, 8'h00);
        wr(PXB_OFS_OUT_MODE0, 8'hff);
        wr(PXB_OFS_LATCH0, 8'h00);
        v = $random(seed);
        ext_en <= 17'h000ff;
        ext_val <= {9'h0, v[7:0]};
        rd(PXB_OFS_LATCH0, v[7:0]);
        ext_en <= '0;
        wr(PXB_OFS_SEL_B, 8'h40);
        wr(PXB_OFS_LATCH0, 8'h3c);
        rd(PXB_OFS_LATCH0, 8'h3c);
        wr(PXB_OFS_OUT_MODE0, 8'h00);
        ext_en <= 17'h00004;
        ext_val <= '0;
        rd(PXB_OFS_LATCH0, 8'h38);
        wr(PXB_OFS_LATCH0, 8'hff);
        wr(PXB_OFS_SEL_B, 8'hc0);
        v = $random(seed);
        ext_en <= 17'h000ff;
        ext_val <= {9'h0, v[7:0]};
        rd(PXB_OFS_LATCH0, v[7:0]);
        ext_val <= 17'h000ff;
        wr(PXB_OFS_SEL_B, 8'h40);
        wr(PXB_OFS_SKIP0, 8'h0f);
        wr(PXB_OFS_IN_MODE0, 8'hf0);
        rd(PXB_OFS_LATCH0, 8'hf0);
        wr(PXB_OFS_IN_MODE0, 8'hff);
        wr(PXB_OFS_SKIP0, 8'h30);
        wr(PXB_OFS_SEL_A, 8'h01);
        wr(PXB_OFS_OUT_MODE0, 8'h10);
        fn_oe <= 17'h00001;
        ext_en <= 17'h00020;
        ext_val <= '0;
        rd(PXB_OFS_LATCH0, 8'hcf);
        look(PXB_FN_UART_RX, 1'b0);
        fn_oe <= '0;
        wr(PXB_OFS_SEL_A, 8'h02);
        wr(PXB_OFS_SKIP0, 8'h05);
        ext_en <= 17'h0000a;
        look(PXB_FN_SPI_SCK, 1'b0);
        look(PXB_FN_SPI_MISO, 1'b0);
        look(PXB_FN_SPI_MOSI, 1'b1);
        wr(PXB_OFS_SKIP0, 8'hff);
        wr(PXB_OFS_SKIP1, 8'hff);
        look(PXB_NFN + PXB_FN_SPI_SCK, 1'b0);
        wr(PXB_OFS_SEL_A, 8'h00);
        ext_en <= '0;
        wr(PXB_OFS_LATCH2, 8'h00);
        rd(PXB_OFS_LATCH2, 8'h00);
        dbg_act <= 1'b1;
        dbg_oe <= 1'b1;
        dbg_out <= 1'b1;
        rd(PXB_OFS_LATCH2, 8'h01);
        look(2 * PXB_NFN, 1'b1);
        test_done();
    end
endmodule
